// ==== hw/watchdog_timer_reset_flags.sv ====
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "wdt_defs.svh"

module watchdog_timer_reset_flags (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wdt_osc,
    input  wire logic        always_on_fuse,
    input  wire logic        global_irq_enable,
    input  wire logic        irq_vector_taken,
    input  wire logic        dog_restart,
    input  wire logic        brownout_evt,
    input  wire logic        pin_rst_evt,
    output logic             timeout_irq,
    output logic             sys_rst_req
);
    logic                 pready_r;
    logic                 pslverr_r;
    logic [31:0]          prdata_r;
    logic                 fuse_s1_r;
    logic                 fuse_r;
    logic                 irq_flag_r;
    logic                 irq_en_r;
    logic                 rst_en_r;
    logic                 unlock_r;
    logic [2:0]           unlock_cnt_r;
    wdt_pkg::ps_code_t    ps_code_r;
    logic                 dog_flag_r;
    logic                 bo_flag_r;
    logic                 pin_flag_r;
    logic                 por_flag_r;
    logic                 sys_rst_req_r;
    logic                 timeout_irq_r;
    logic                 hit_ctrl;
    logic                 hit_cause;
    logic                 acc;
    logic                 wr_en;
    logic                 wr_ctrl;
    logic                 wr_cause;
    logic                 timeout;
    logic                 do_irq;
    logic                 do_rst;
    logic [`REG_W-1:0]    ctrl_rd;
    logic [`REG_W-1:0]    cause_rd;
    wdt_pkg::mode_e       mode;

    wdt_if wif ();

    wdt_count u_count (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .osc_pin (wdt_osc),
        .bus     (wif.core)
    );

    // counter only runs in a live mode; restart comes straight from the core
    assign wif.restart = dog_restart;
    assign wif.run     = (mode != wdt_pkg::MODE_STOPPED);
    assign wif.code    = ps_code_r;
    assign timeout     = wif.timeout;

    // fuse is a static strap but still crosses from outside: two flops
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            fuse_s1_r <= 1'b0;
            fuse_r    <= 1'b0;
        end
        else
        begin
            fuse_s1_r <= always_on_fuse;
            fuse_r    <= fuse_s1_r;
        end
    end

    // mode from the fuse and the two enables
    always_comb
    begin
        if (fuse_r)
            mode = wdt_pkg::MODE_RESET;
        else
        begin
            case ({rst_en_r, irq_en_r})
                2'b00:   mode = wdt_pkg::MODE_STOPPED;
                2'b01:   mode = wdt_pkg::MODE_IRQ;
                2'b10:   mode = wdt_pkg::MODE_RESET;
                2'b11:   mode = wdt_pkg::MODE_COMBINED;
                default: mode = wdt_pkg::MODE_STOPPED;
            endcase
        end
    end

    // combined mode: a pending flag means the last interrupt went unserviced
    assign do_irq = timeout & ((mode == wdt_pkg::MODE_IRQ)
                  | ((mode == wdt_pkg::MODE_COMBINED) & ~irq_flag_r));
    assign do_rst = timeout & ((mode == wdt_pkg::MODE_RESET)
                  | ((mode == wdt_pkg::MODE_COMBINED) & irq_flag_r));

    // apb decode; a write lands only at the edge where the master sees pready
    assign hit_ctrl  = (paddr == `CTRL_OFS);
    assign hit_cause = (paddr == `CAUSE_OFS);
    assign acc       = psel & penable;
    assign wr_en     = acc & pready_r & pwrite;
    assign wr_ctrl   = wr_en & hit_ctrl;
    assign wr_cause  = wr_en & hit_cause;

    // read views of the two byte registers
    always_comb
    begin
        ctrl_rd = '0;
        ctrl_rd[`CS_IRQ_FLAG] = irq_flag_r;
        ctrl_rd[`CS_IRQ_EN]   = irq_en_r;
        ctrl_rd[`CS_PS_TOP]   = ps_code_r[`PS_TOP_BIT];
        ctrl_rd[`CS_UNLOCK]   = unlock_r;
        ctrl_rd[`CS_RST_EN]   = rst_en_r;
        ctrl_rd[`CS_PS_LOW_HI:`CS_PS_LOW_LO] = ps_code_r[`PS_TOP_BIT-1:0];
        cause_rd = '0;
        cause_rd[`RC_DOG] = dog_flag_r;
        cause_rd[`RC_BO]  = bo_flag_r;
        cause_rd[`RC_PIN] = pin_flag_r;
        cause_rd[`RC_POR] = por_flag_r;
    end

    // one wait state: data and error are loaded on the first access edge
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end
        else
        begin
            pready_r  <= acc & ~pready_r;
            pslverr_r <= acc & ~pready_r & ~(hit_ctrl | hit_cause);
            if (acc & ~pready_r & ~pwrite)
            begin
                prdata_r <= '0;
                if (hit_ctrl)
                    prdata_r[`REG_W-1:0] <= ctrl_rd;
                else if (hit_cause)
                    prdata_r[`REG_W-1:0] <= cause_rd;
            end
        end
    end

    // rst_b acts as power-on: other causes cleared, power-on cause marked;
    // hardware sets win over a software zero in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            dog_flag_r <= 1'b0;
            bo_flag_r  <= 1'b0;
            pin_flag_r <= 1'b0;
            por_flag_r <= 1'b1;
        end
        else
        begin
            dog_flag_r <= sys_rst_req_r | (dog_flag_r & ~(wr_cause & ~pwdata[`RC_DOG]));
            bo_flag_r  <= brownout_evt | (bo_flag_r & ~(wr_cause & ~pwdata[`RC_BO]));
            pin_flag_r <= pin_rst_evt | (pin_flag_r & ~(wr_cause & ~pwdata[`RC_PIN]));
            por_flag_r <= por_flag_r & ~(wr_cause & ~pwdata[`RC_POR]);
        end
    end

    // interrupt flag: timeout set beats vector and write-one clears
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            irq_flag_r <= 1'b0;
        else if (do_irq)
            irq_flag_r <= 1'b1;
        else if (irq_vector_taken | (wr_ctrl & pwdata[`CS_IRQ_FLAG]))
            irq_flag_r <= 1'b0;
    end

    // interrupt enable; vector in combined mode drops to reset-only
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            irq_en_r <= 1'b0;
        else if (fuse_r)
            irq_en_r <= 1'b0;
        else if (irq_vector_taken & rst_en_r)
            irq_en_r <= 1'b0;
        else if (wr_ctrl)
            irq_en_r <= pwdata[`CS_IRQ_EN];
    end

    // unlock window: armed only by writing ones to unlock and reset enable
    // together; any other control write consumes it, else it lapses after four cycles
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            unlock_r     <= 1'b0;
            unlock_cnt_r <= `UNLOCK_IDLE;
        end
        else if (wr_ctrl & pwdata[`CS_UNLOCK] & pwdata[`CS_RST_EN])
        begin
            unlock_r     <= 1'b1;
            unlock_cnt_r <= `UNLOCK_CYCLES;
        end
        else if (wr_ctrl | (unlock_cnt_r == `UNLOCK_LAST))
        begin
            unlock_r     <= 1'b0;
            unlock_cnt_r <= `UNLOCK_IDLE;
        end
        else if (unlock_cnt_r != `UNLOCK_IDLE)
            unlock_cnt_r <= unlock_cnt_r - `UNLOCK_LAST;
    end

    // reset enable: setting is free, clearing needs the unlock window;
    // the dog cause and the fuse pin it high so a failing system keeps resetting
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            rst_en_r <= 1'b0;
        else if (fuse_r | dog_flag_r)
            rst_en_r <= 1'b1;
        else if (wr_ctrl & (pwdata[`CS_RST_EN] | unlock_r))
            rst_en_r <= pwdata[`CS_RST_EN];
    end

    // prescale code changes only inside the unlock window
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            ps_code_r <= `PS_RESET;
        else if (wr_ctrl & unlock_r)
        begin
            ps_code_r[`PS_TOP_BIT] <= pwdata[`CS_PS_TOP];
            ps_code_r[`PS_TOP_BIT-1:0] <= pwdata[`CS_PS_LOW_HI:`CS_PS_LOW_LO];
        end
    end

    // outputs: one-cycle reset request and gated interrupt request
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            sys_rst_req_r <= 1'b0;
            timeout_irq_r <= 1'b0;
        end
        else
        begin
            sys_rst_req_r <= do_rst;
            timeout_irq_r <= irq_flag_r & irq_en_r & global_irq_enable;
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign sys_rst_req = sys_rst_req_r;
    assign timeout_irq = timeout_irq_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    cause_rsvd_a: assert property (pready_r && hit_cause && !pwrite
        |-> prdata_r[31:`REG_W/2] == '0)
        else $error("reserved cause bits read nonzero");
    dog_cause_a: assert property (sys_rst_req_r |=> dog_flag_r)
        else $error("dog cause not set after reset request");
    bo_cause_a: assert property (brownout_evt |=> bo_flag_r)
        else $error("brown-out cause not set");
    pin_cause_a: assert property (pin_rst_evt |=> pin_flag_r)
        else $error("pin cause not set");
    por_keep_a: assert property (por_flag_r && !(wr_cause && !pwdata[`RC_POR])
        |=> por_flag_r)
        else $error("power-on cause lost without software clear");
    irq_only_a: assert property (timeout && mode == wdt_pkg::MODE_IRQ
        |=> irq_flag_r && !sys_rst_req_r ##1 !sys_rst_req_r)
        else $error("interrupt mode timeout misbehaved");
    irq_gate_a: assert property (timeout_irq_r
        |-> $past(irq_flag_r) && $past(irq_en_r) && $past(global_irq_enable))
        else $error("interrupt request without both enables");
    irq_mode_a: assert property (mode == wdt_pkg::MODE_IRQ |=> !sys_rst_req_r)
        else $error("reset issued in interrupt mode");
    comb_first_a: assert property (timeout && mode == wdt_pkg::MODE_COMBINED && !irq_flag_r
        |=> irq_flag_r && !sys_rst_req_r)
        else $error("combined first timeout did not interrupt");
    vec_clear_a: assert property (irq_vector_taken && mode == wdt_pkg::MODE_COMBINED && !do_irq
        |=> !irq_en_r && !irq_flag_r && rst_en_r)
        else $error("vector did not fall back to reset-only");
    comb_second_a: assert property (timeout && mode == wdt_pkg::MODE_COMBINED && irq_flag_r
        |=> sys_rst_req_r ##1 !sys_rst_req_r)
        else $error("unserviced combined timeout gave no reset");
    unlock_lapse_a: assert property ($rose(unlock_r)
        |-> ##4 (!unlock_r || $past(wr_ctrl)))
        else $error("unlock window outlived four cycles");
    rst_en_guard_a: assert property ($fell(rst_en_r) |-> $past(unlock_r) && $past(wr_ctrl))
        else $error("reset enable cleared without unlock");
    ps_guard_a: assert property (ps_code_r != $past(ps_code_r) |-> $past(unlock_r))
        else $error("prescale changed without unlock");
    rst_en_hold_a: assert property (dog_flag_r |=> rst_en_r)
        else $error("reset enable dropped while dog cause set");
    fuse_lock_a: assert property (fuse_r |=> rst_en_r && !irq_en_r)
        else $error("fuse did not force reset-only");
    stopped_a: assert property (mode == wdt_pkg::MODE_STOPPED ##1 mode == wdt_pkg::MODE_STOPPED
        |-> !timeout ##1 !sys_rst_req_r)
        else $error("stopped watchdog acted");
    rst_pulse_a: assert property (sys_rst_req_r |=> !sys_rst_req_r)
        else $error("reset request longer than one cycle");

    irq_mode_c: cover property (timeout && mode == wdt_pkg::MODE_IRQ);
    comb_reset_c: cover property (timeout && mode == wdt_pkg::MODE_COMBINED && irq_flag_r);
    unlock_clear_c: cover property ($fell(rst_en_r));
    vector_c: cover property (irq_vector_taken && mode == wdt_pkg::MODE_COMBINED);
endmodule
`default_nettype wire

// ==== hw/wdt_defs.svh ====
// Behaviour
// - reset cause bits 7:4 always read zero
// - watchdog cause set by dog reset, cleared power-on/zero
// - brown-out cause set by brown-out, cleared power-on/zero
// - pin cause set by pin reset, cleared power-on/zero
// - power-on cause set at power-on, cleared by zero
// - irq flag set on timeout, cleared vector/one
// - irq request needs global and watchdog enable
// - irq-only mode interrupts each timeout, never resets
// - combined mode first timeout interrupts, not resets
// - vector in combined mode clears enable and flag
// - unserviced combined timeout issues system reset
// - unlock gates changes, self-clears after four cycles
// - reset enable held while dog cause set
// - prescale code selects 2048 to 1048576 cycles
// - reserved prescale codes use a valid period
// - unlock write then settings write within four
// - counter advances on separate oscillator cycles
// - restart instruction clears counter before timeout
// - always-on fuse forces reset-only mode
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define CTRL_OFS      12'h060
`define CAUSE_OFS     12'h064
`define CS_IRQ_FLAG   7
`define CS_IRQ_EN     6
`define CS_PS_TOP     5
`define CS_UNLOCK     4
`define CS_RST_EN     3
`define CS_PS_LOW_HI  2
`define CS_PS_LOW_LO  0
`define PS_TOP_BIT    3
`define RC_DOG        3
`define RC_BO         2
`define RC_PIN        1
`define RC_POR        0
`define REG_W         8
`define UNLOCK_CYCLES 3'h4
`define UNLOCK_LAST   3'h1
`define UNLOCK_IDLE   3'h0
`define PS_CODE_MAX   4'h9
`define PS_RESET      4'h0
`define OSC_BASE      21'h000800
`define LIM_ONE       21'h000001
`define CNT_W         20
`define CNT_ONE       20'h00001
`define CNT_ZERO      20'h00000

`endif

// ==== hw/wdt_pkg.sv ====
package wdt_pkg;
    typedef enum logic [1:0] {MODE_STOPPED, MODE_IRQ, MODE_RESET, MODE_COMBINED} mode_e;
    typedef logic [3:0] ps_code_t;
endpackage

// ==== hw/wdt_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface wdt_if;
    logic              restart;
    logic              run;
    wdt_pkg::ps_code_t code;
    logic              timeout;
    modport core (input restart, input run, input code, output timeout);
    modport ctrl (output restart, output run, output code, input timeout);
endinterface
`default_nettype wire

// ==== hw/wdt_count.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_count (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic osc_pin,
    wdt_if.core       bus
);
    logic              osc_s1_r;
    logic              osc_s2_r;
    logic              osc_d_r;
    logic              osc_tick;
    wdt_pkg::ps_code_t code_eff;
    logic [`CNT_W:0]   lim;
    logic [`CNT_W:0]   lim_m1;
    logic [`CNT_W-1:0] term;
    logic [`CNT_W-1:0] count_r;
    logic              timeout_r;

    // oscillator pin is asynchronous to ref_clk: two flops before edge detect
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_d_r  <= 1'b0;
        end
        else
        begin
            osc_s1_r <= osc_pin;
            osc_s2_r <= osc_s1_r;
            osc_d_r  <= osc_s2_r;
        end
    end
    assign osc_tick = osc_s2_r & ~osc_d_r;

    // reserved codes fall back to the longest valid period
    assign code_eff = (bus.code > `PS_CODE_MAX) ? `PS_CODE_MAX : bus.code;
    assign lim      = `OSC_BASE << code_eff;
    assign lim_m1   = lim - `LIM_ONE;
    assign term     = lim_m1[`CNT_W-1:0];

    // counter wraps at the terminal count and flags one timeout pulse
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            count_r   <= `CNT_ZERO;
            timeout_r <= 1'b0;
        end
        else if (bus.restart | ~bus.run)
        begin
            count_r   <= `CNT_ZERO;
            timeout_r <= 1'b0;
        end
        else if (osc_tick && count_r == term)
        begin
            count_r   <= `CNT_ZERO;
            timeout_r <= 1'b1;
        end
        else
        begin
            timeout_r <= 1'b0;
            if (osc_tick)
                count_r <= count_r + `CNT_ONE;
        end
    end
    assign bus.timeout = timeout_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    restart_clears_a: assert property (bus.restart |=> count_r == `CNT_ZERO && !timeout_r)
        else $error("restart did not clear the counter");
    clamp_valid_a: assert property (bus.code > `PS_CODE_MAX
        |-> term == {`CNT_W{1'b1}})
        else $error("reserved prescale code not held at the longest period");
    tick_only_a: assert property (count_r != $past(count_r) && count_r != `CNT_ZERO
        |-> $past(osc_tick))
        else $error("counter moved without oscillator edge");
endmodule
`default_nettype wire

// ==== tb/cpu_reset_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module cpu_reset_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       timeout_irq,
    input  wire logic       sys_rst_req,
    input  wire logic       serve,
    output logic            irq_vector_taken,
    output logic      [7:0] rst_count
);
    logic [2:0] hold_r;

    // vector taken once per request; hold-off covers the late-falling request
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            irq_vector_taken <= 1'b0;
            hold_r           <= 3'h0;
        end
        else if (irq_vector_taken)
        begin
            irq_vector_taken <= 1'b0;
            hold_r           <= 3'h4;
        end
        else if (hold_r != 3'h0)
            hold_r <= hold_r - 3'h1;
        else if (serve && timeout_irq)
            irq_vector_taken <= 1'b1;
    end

    // reset logic only counts requests; the block under test is not reset by them
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            rst_count <= 8'h00;
        else if (sys_rst_req)
            rst_count <= rst_count + 8'h01;
    end
endmodule
`default_nettype wire

// ==== tb/test_watchdog_timer_reset_flags.sv ====
`timescale 1ns/100ps
`default_nettype none

module test_watchdog_timer_reset_flags;
    localparam logic [11:0] CTRL  = 12'h060;
    localparam logic [11:0] CAUSE = 12'h064;
    localparam logic [11:0] HOLE  = 12'h068;
    typedef struct {logic wr; logic [7:0] data; logic err;} note_s;

    logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        wdt_osc, always_on_fuse, global_irq_enable, irq_vector_taken;
    logic        dog_restart, brownout_evt, pin_rst_evt, timeout_irq, sys_rst_req;
    logic        serve;
    logic [7:0]  rst_count, rst0;
    int          failures, compares, seed, irq_hi, irq0, n;
    note_s       note_q[$];
    note_s       nt;

    watchdog_timer_reset_flags i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wdt_osc(wdt_osc),
        .always_on_fuse(always_on_fuse), .global_irq_enable(global_irq_enable),
        .irq_vector_taken(irq_vector_taken), .dog_restart(dog_restart),
        .brownout_evt(brownout_evt), .pin_rst_evt(pin_rst_evt),
        .timeout_irq(timeout_irq), .sys_rst_req(sys_rst_req)
    );

    cpu_reset_model i_cpu (
        .ref_clk(ref_clk), .rst_b(rst_b), .timeout_irq(timeout_irq),
        .sys_rst_req(sys_rst_req), .serve(serve),
        .irq_vector_taken(irq_vector_taken), .rst_count(rst_count)
    );

    // 40 MHz system clock
    always #12.5 ref_clk = ~ref_clk;

    // fast watchdog oscillator: one rising edge every four system cycles
    always
    begin
        repeat (2) @(posedge ref_clk);
        wdt_osc <= ~wdt_osc;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one transfer; request stays up until pready is seen, release is left to the caller
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [7:0] exp, input logic err);
        logic [31:0] rnd;
        int          k;
        rnd = $random(seed);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {rnd[23:0], d};
        note_q.push_back('{wr, exp, err});
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
            check("pready", 32'h0, 32'h1);
    endtask

    task automatic idle(input int c);
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (c) @(posedge ref_clk);
    endtask

    // one-cycle event pulse: 0 restart, 1 brown-out, 2 pin reset
    task automatic ev(input int k);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k == 0) dog_restart <= 1'b1;
        if (k == 1) brownout_evt <= 1'b1;
        if (k == 2) pin_rst_evt <= 1'b1;
        @(posedge ref_clk);
        dog_restart  <= 1'b0;
        brownout_evt <= 1'b0;
        pin_rst_evt  <= 1'b0;
    endtask

    // counts cycles until the interrupt (r=0) or the reset request (r=1) is seen
    task automatic wait_ev(input logic r, input int lim, input int lo, input int hi);
        idle(1);
        n = 1;
        while ((r ? sys_rst_req : timeout_irq) !== 1'b1 && n < lim)
        begin
            @(posedge ref_clk);
            n++;
        end
        check(r ? "reset delay" : "irq delay", {31'h0, (n >= lo) && (n <= hi)}, 32'h1);
    endtask

    // each finished transfer takes the oldest note and compares
    always @(posedge ref_clk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            if (note_q.size() == 0)
                check("note queue", 32'h0, 32'h1);
            else
            begin
                nt = note_q.pop_front();
                check("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
                if (!nt.wr)
                    check("prdata", prdata, {24'h0, nt.data});
            end
        end
        if (timeout_irq === 1'b1)
            irq_hi <= irq_hi + 1;
    end

    // hang guard, reckoned well above the scenario total
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        failures++;
        print_verdict();
    end

    initial
    begin
        ref_clk = 1'b0; rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; wdt_osc = 1'b0; always_on_fuse = 1'b0;
        global_irq_enable = 1'b1; dog_restart = 1'b0; brownout_evt = 1'b0;
        pin_rst_evt = 1'b0; serve = 1'b1; failures = 0; compares = 0;
        seed = 6264; irq_hi = 0;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        // reset values, unmapped hole, cause flags
        apb(0, CAUSE, 8'h00, 8'h01, 0);
        apb(0, CTRL, 8'h00, 8'h00, 0);
        apb(0, HOLE, 8'h00, 8'h00, 1);
        ev(1);
        ev(2);
        apb(0, CAUSE, 8'h00, 8'h07, 0);
        apb(1, CAUSE, 8'hfe, 8'h00, 0);
        apb(0, CAUSE, 8'h00, 8'h06, 0);
        apb(1, CAUSE, 8'hfb, 8'h00, 0);
        apb(0, CAUSE, 8'h00, 8'h02, 0);
        apb(1, CAUSE, 8'h00, 8'h00, 0);
        apb(0, CAUSE, 8'h00, 8'h00, 0);
        // timed unlock: prescale locked, window back-to-back, late write ignored
        apb(1, CTRL, 8'h0f, 8'h00, 0);
        apb(0, CTRL, 8'h00, 8'h08, 0);
        apb(1, CTRL, 8'h18, 8'h00, 0);
        apb(1, CTRL, 8'h01, 8'h00, 0);
        apb(0, CTRL, 8'h00, 8'h01, 0);
        apb(1, CTRL, 8'h18, 8'h00, 0);
        idle(6);
        apb(1, CTRL, 8'h00, 8'h00, 0);
        apb(0, CTRL, 8'h00, 8'h09, 0);
        // interrupt-only mode at the doubled period, vector served
        ev(0);
        apb(1, CTRL, 8'h19, 8'h00, 0);
        apb(1, CTRL, 8'h41, 8'h00, 0);
        ev(0);
        wait_ev(0, 17000, 16200, 16500);
        idle(8);
        apb(0, CTRL, 8'h00, 8'h41, 0);
        check("resets", {24'h0, rst_count}, 32'h0);
        // global enable masks the request; write one clears the flag
        serve <= 1'b0;
        global_irq_enable <= 1'b0;
        ev(0);
        apb(1, CTRL, 8'h19, 8'h00, 0);
        apb(1, CTRL, 8'h40, 8'h00, 0);
        ev(0);
        irq0 = irq_hi;
        idle(8500);
        check("masked irq", irq_hi, irq0);
        apb(0, CTRL, 8'h00, 8'hc0, 0);
        global_irq_enable <= 1'b1;
        wait_ev(0, 6, 1, 4);
        apb(1, CTRL, 8'hc0, 8'h00, 0);
        apb(0, CTRL, 8'h00, 8'h40, 0);
        // combined mode: interrupt first, reset on the unserviced second timeout
        apb(1, CTRL, 8'h48, 8'h00, 0);
        ev(0);
        rst0 = rst_count;
        wait_ev(0, 8400, 8100, 8300);
        check("no reset", {24'h0, rst_count}, {24'h0, rst0});
        wait_ev(1, 8400, 8100, 8300);
        idle(3);
        apb(0, CAUSE, 8'h00, 8'h08, 0);
        apb(0, CTRL, 8'h00, 8'hc8, 0);
        serve <= 1'b1;
        idle(8);
        apb(0, CTRL, 8'h00, 8'h08, 0);
        serve <= 1'b0;
        // reset enable held while the dog cause flag is set
        ev(0);
        apb(1, CTRL, 8'h18, 8'h00, 0);
        apb(1, CTRL, 8'h00, 8'h00, 0);
        apb(0, CTRL, 8'h00, 8'h08, 0);
        apb(1, CAUSE, 8'h00, 8'h00, 0);
        apb(1, CTRL, 8'h18, 8'h00, 0);
        apb(1, CTRL, 8'h22, 8'h00, 0);
        apb(0, CTRL, 8'h00, 8'h22, 0);
        // stopped: no action at all
        rst0 = rst_count;
        irq0 = irq_hi;
        idle(8500);
        check("stopped irq", irq_hi, irq0);
        check("stopped reset", {24'h0, rst_count}, {24'h0, rst0});
        // back to the shortest period so the fuse timeout stays in reach
        apb(1, CTRL, 8'h18, 8'h00, 0);
        apb(1, CTRL, 8'h00, 8'h00, 0);
        // fuse forces reset-only; restarts keep it quiet, then a one-cycle request
        always_on_fuse <= 1'b1;
        idle(5);
        apb(0, CTRL, 8'h00, 8'h08, 0);
        apb(1, CTRL, 8'h40, 8'h00, 0);
        apb(0, CTRL, 8'h00, 8'h08, 0);
        ev(0);
        idle(6000);
        ev(0);
        idle(6000);
        check("restart reset", {24'h0, rst_count}, {24'h0, rst0});
        wait_ev(1, 3000, 2000, 2400);
        @(posedge ref_clk);
        check("reset width", {31'h0, sys_rst_req}, 32'h0);
        idle(3);
        apb(0, CAUSE, 8'h00, 8'h08, 0);
        idle(2);
        print_verdict();
    end
endmodule
`default_nettype wire
